// ==== rtl/agmr_buf2.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-entry skid buffer, valid/ready on both sides
module agmr_buf2 #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem_reg [2];   // Storage
    logic [WIDTH-1:0] mem_next [2];
    logic [1:0] cnt_reg, cnt_next;   // Occupancy 0..2
    logic rd_reg, rd_next;           // Read slot
    logic wr_reg, wr_next;           // Write slot
    logic push, pop;

    // Next state
    always_comb begin
        push = inValid && (cnt_reg != 2'd2);
        pop = outReady && (cnt_reg != 2'd0);
        mem_next = mem_reg;
        if (push) begin
            mem_next[wr_reg] = inData;
        end
        wr_next = push ? ~wr_reg : wr_reg;
        rd_next = pop ? ~rd_reg : rd_reg;
        cnt_next = cnt_reg + 2'(push) - 2'(pop);
    end

    // Registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            cnt_reg <= 2'd0;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
        end else if (clkEn) begin
            mem_reg <= mem_next;
            cnt_reg <= cnt_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
        end
    end

    assign inReady = (cnt_reg != 2'd2);
    assign outValid = (cnt_reg != 2'd0);
    assign outData = mem_reg[rd_reg];
endmodule // agmr_buf2
`default_nettype wire

// ==== rtl/agmr_mixer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Primary group selector picks group one to four
// - Secondary selector adds off, disabling that group
// - Status per selector: absent, present, or off
// - Demux mode uses same selectors for extraction
// - Per-channel gain from -70 to +12 dB
// - Any input routes to any output subset
// - Bank one channels 1-4, bank two 5-8
// - Tie forces pair to share one gain
// - Default action returns channel gain to unity
// - Invert negates channel samples before mixing
// - Non-audio channels bypass gain, invert, mixing
// - Peak flag when output exceeds headroom threshold
// - VU: above 0, above -20, or below
// - Monitor carries exactly one selected channel pair
// - Monitor volume 0-100 percent, default full
// - Headroom: clipping or 2-10 dB in steps
// - Zero VU: -18 or -20 dBFS chosen by ctrl bit 16, which lies beyond the 16-bit ctrl_reg
module agmr_mixer (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // Avalon-MM slave
    input wire logic [agmr_pkg::ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [agmr_pkg::DATA_W-1:0] avsWriteData,
    output logic [agmr_pkg::DATA_W-1:0] avsReadData,
    output logic avsWaitRequest,
    // Group presence from disembedder (pin domain)
    input wire logic [3:0] grpPresent,
    // Input sample frame, all eight channels
    input wire logic inValid,
    output logic inReady,
    input wire logic [agmr_pkg::NCH*agmr_pkg::SMP_W-1:0] inSamples,
    // Output sample frame
    output logic outValid,
    input wire logic outReady,
    output logic [agmr_pkg::NCH*agmr_pkg::SMP_W-1:0] outSamples,
    // Monitor pair
    output logic [2*agmr_pkg::SMP_W-1:0] monSamples,
    // Group selection toward embedder/disembedder
    output logic [2:0] selGroupA,
    output logic [2:0] selGroupB,
    output logic demuxMode
);
    import agmr_pkg::*;

    // ****************************************************
    // Registers
    // ****************************************************
    logic [15:0] ctrl_reg, ctrl_next;             // Group, mode, peak; ref bit 16 lies outside
    logic [1:0] monPair_reg, monPair_next;        // Monitor pair
    logic [6:0] monVol_reg, monVol_next;          // Monitor volume percent
    logic [3:0] tie_reg, tie_next;                // Per-pair tie
    logic [7:0] inv_reg, inv_next;                // Per-channel invert
    logic [7:0] data_reg, data_next;              // Non-audio flags
    logic [GAIN_W-1:0] gain_reg [NCH];            // Gain codes
    logic [GAIN_W-1:0] gain_next [NCH];
    logic [NCH-1:0] route_reg [NCH];              // Row per input
    logic [NCH-1:0] route_next [NCH];
    logic [7:0] peak_reg, peak_next;              // Sticky-free live peak
    logic [15:0] vu_reg, vu_next;                 // Two bits per output
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;                      // Answer phase
    logic [3:0] pres1_reg, pres2_reg;             // Presence sync
    logic [NCH*SMP_W-1:0] mix_reg, mix_next;
    logic mixValid_reg, mixValid_next;
    logic [2*SMP_W-1:0] mon_reg, mon_next;
    logic [2:0] stsA, stsB;
    logic bufReady;
    logic [3:0] wIdx;

    // ****************************************************
    // Bus access and register updates
    // ****************************************************
    // Requests answered one cycle after they are seen
    always_comb begin
        ctrl_next = ctrl_reg;
        monPair_next = monPair_reg;
        monVol_next = monVol_reg;
        tie_next = tie_reg;
        inv_next = inv_reg;
        data_next = data_reg;
        gain_next = gain_reg;
        route_next = route_reg;
        rdata_next = rdata_reg;
        ack_next = (avsRead || avsWrite) && !ack_reg;
        wIdx = {1'b0, avsAddress[4:2]};
        if (avsWrite && !ack_reg) begin
            if (avsAddress == OFF_CTRL) begin
                ctrl_next = avsWriteData[15:0];
                // Illegal selectors are ignored
                if (avsWriteData[CTRL_GA+:3] == GRP_OFF || avsWriteData[CTRL_GA+:3] > GRP_MAX) begin
                    ctrl_next[CTRL_GA+:3] = ctrl_reg[CTRL_GA+:3];
                end
                if (avsWriteData[CTRL_GB+:3] > GRP_MAX) begin
                    ctrl_next[CTRL_GB+:3] = ctrl_reg[CTRL_GB+:3];
                end
                if (avsWriteData[CTRL_PEAK+:3] > 3'd5) begin
                    ctrl_next[CTRL_PEAK+:3] = ctrl_reg[CTRL_PEAK+:3];
                end
            end else if (avsAddress == OFF_MON) begin
                monPair_next = avsWriteData[1:0];
                if (avsWriteData[14:8] <= VOL_FULL) begin
                    monVol_next = avsWriteData[14:8];
                end
            end else if (avsAddress == OFF_TIE) begin
                tie_next = avsWriteData[3:0];
            end else if (avsAddress == OFF_DEFAULT) begin
                // Write-one pulse per channel restores unity
                for (int c = 0; c < NCH; c++) begin
                    if (avsWriteData[c]) begin
                        gain_next[c] = GAIN_UNITY;
                    end
                end
            end else if (avsAddress == OFF_INVERT) begin
                inv_next = avsWriteData[7:0];
            end else if (avsAddress == OFF_DATA) begin
                data_next = avsWriteData[7:0];
            end else if (avsAddress[7:5] == OFF_GAIN0[7:5]) begin
                if (avsWriteData[7:0] <= GAIN_MAXC) begin
                    gain_next[wIdx[2:0]] = avsWriteData[7:0];
                    // Tied pair follows its partner
                    if (tie_reg[wIdx[2:1]]) begin
                        gain_next[wIdx[2:0] ^ 3'd1] = avsWriteData[7:0];
                    end
                end
            end else if (avsAddress[7:5] == OFF_ROUTE0[7:5]) begin
                route_next[wIdx[2:0]] = avsWriteData[7:0];
            end
        end
        if (avsRead && !ack_reg) begin
            unique case (1'b1)
                avsAddress == OFF_CTRL: rdata_next = {16'h0000, ctrl_reg};
                avsAddress == OFF_STATUS: rdata_next = {24'h00_0000, 1'b0, stsB, 1'b0, stsA};
                avsAddress == OFF_MON: rdata_next = {17'h0_0000, monVol_reg, 6'h00, monPair_reg};
                avsAddress == OFF_TIE: rdata_next = {28'h000_0000, tie_reg};
                avsAddress == OFF_INVERT: rdata_next = {24'h00_0000, inv_reg};
                avsAddress == OFF_DATA: rdata_next = {24'h00_0000, data_reg};
                avsAddress == OFF_PEAK: rdata_next = {24'h00_0000, peak_reg};
                avsAddress == OFF_VU: rdata_next = {16'h0000, vu_reg};
                avsAddress[7:5] == OFF_GAIN0[7:5]: rdata_next = {24'h00_0000, gain_reg[wIdx[2:0]]};
                avsAddress[7:5] == OFF_ROUTE0[7:5]: rdata_next = {24'h00_0000, route_reg[wIdx[2:0]]};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Register bank and synchroniser
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= 16'h0001;
            monPair_reg <= 2'd0;
            monVol_reg <= VOL_FULL;
            tie_reg <= 4'h0;
            inv_reg <= 8'h00;
            data_reg <= 8'h00;
            for (int c = 0; c < NCH; c++) begin
                gain_reg[c] <= GAIN_UNITY;
                route_reg[c] <= NCH'(1) << c;
            end
            rdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            pres1_reg <= 4'h0;
            pres2_reg <= 4'h0;
        end else if (clkEn) begin
            ctrl_reg <= ctrl_next;
            monPair_reg <= monPair_next;
            monVol_reg <= monVol_next;
            tie_reg <= tie_next;
            inv_reg <= inv_next;
            data_reg <= data_next;
            gain_reg <= gain_next;
            route_reg <= route_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            pres1_reg <= grpPresent;
            pres2_reg <= pres1_reg;
        end
    end

    // Group status: 0 none, 1-4 group ok, 5 off
    always_comb begin
        stsA = pres2_reg[ctrl_reg[CTRL_GA+:2] - 2'd1] ? ctrl_reg[CTRL_GA+:3] : STS_NONE;
        if (ctrl_reg[CTRL_GB+:3] == GRP_OFF) begin
            stsB = STS_OFF;
        end else begin
            stsB = pres2_reg[ctrl_reg[CTRL_GB+:2] - 2'd1] ? ctrl_reg[CTRL_GB+:3] : STS_NONE;
        end
    end

    // ****************************************************
    // Mixing datapath
    // ****************************************************
    // Gain code to Q8.16 linear factor, 6 dB per doubling approx
    function automatic logic [23:0] gain_lin(input logic [GAIN_W-1:0] code);
        logic [7:0] db;
        logic [23:0] base;
        db = code;
        base = 24'h01_0000 >> 7'((GAIN_UNITY - db) / 8'd6);
        if (db >= GAIN_UNITY) begin
            base = 24'h01_0000 << 4'((db - GAIN_UNITY) / 8'd6);
        end
        return base;
    endfunction

    // Saturate accumulator to sample width
    function automatic logic [SMP_W-1:0] sat(input logic signed [ACC_W-1:0] v);
        if (v > $signed({{(ACC_W-SMP_W+1){1'b0}}, {(SMP_W-1){1'b1}}})) begin
            return {1'b0, {(SMP_W-1){1'b1}}};
        end else if (v < -$signed({{(ACC_W-SMP_W+1){1'b0}}, {(SMP_W-1){1'b1}}})) begin
            return {1'b1, {(SMP_W-2){1'b0}}, 1'b1};
        end
        return v[SMP_W-1:0];
    endfunction

    // One frame per accepted input
    always_comb begin
        logic signed [ACC_W-1:0] acc [NCH];
        logic signed [ACC_W-1:0] term;
        logic signed [SMP_W-1:0] s;
        logic signed [ACC_W-1:0] mv;
        for (int o = 0; o < NCH; o++) begin
            acc[o] = '0;
        end
        term = '0;
        s = '0;
        mv = '0;
        mix_next = mix_reg;
        mixValid_next = mixValid_reg && !bufReady;
        mon_next = mon_reg;
        if (inValid && inReady) begin
            for (int i = 0; i < NCH; i++) begin
                s = $signed(inSamples[i*SMP_W+:SMP_W]);
                if (inv_reg[i] && !data_reg[i]) begin
                    s = -s;
                end
                term = ACC_W'(s) * $signed({1'b0, gain_lin(gain_reg[i])});
                term = term >>> 16;
                for (int o = 0; o < NCH; o++) begin
                    if (data_reg[i]) begin
                        // Non-audio passes straight to its own output
                        if (o == i) begin
                            acc[o] = acc[o] + ACC_W'(s);
                        end
                    end else if (route_reg[i][o]) begin
                        acc[o] = acc[o] + term;
                    end
                end
            end
            for (int o = 0; o < NCH; o++) begin
                mix_next[o*SMP_W+:SMP_W] = sat(acc[o]);
            end
            for (int k = 0; k < 2; k++) begin
                mv = ACC_W'($signed(mix_next[(2*monPair_reg+k)*SMP_W+:SMP_W])) * $signed({33'h0, monVol_reg});
                mon_next[k*SMP_W+:SMP_W] = SMP_W'(mv / $signed(ACC_W'(VOL_DIV)));
            end
            mixValid_next = 1'b1;
        end
    end

    // ****************************************************
    // Metering on each frame as it is mixed
    // ****************************************************
    always_comb begin
        logic [SMP_W-2:0] mag;
        logic [SMP_W-2:0] pk;
        logic [SMP_W-2:0] v0;
        logic [SMP_W-2:0] v20;
        mag = '0;
        unique case (ctrl_reg[CTRL_PEAK+:3])
            3'd1: pk = PEAK_2DB;
            3'd2: pk = PEAK_4DB;
            3'd3: pk = PEAK_6DB;
            3'd4: pk = PEAK_8DB;
            3'd5: pk = PEAK_10DB;
            default: pk = PEAK_CLIP;
        endcase
        v0 = ctrl_reg[CTRL_REF] ? VU18_0 : VU20_0;
        v20 = ctrl_reg[CTRL_REF] ? VU18_M20 : VU20_M20;
        peak_next = peak_reg;
        vu_next = vu_reg;
        if (mixValid_next && !mixValid_reg) begin
            for (int o = 0; o < NCH; o++) begin
                mag = mix_next[o*SMP_W+SMP_W-1] ? (SMP_W-1)'(-mix_next[o*SMP_W+:SMP_W])
                    : mix_next[o*SMP_W+:SMP_W-1];
                peak_next[o] = (pk == PEAK_CLIP) ? (mag >= pk) : (mag > pk);
                vu_next[2*o+:2] = (mag > v0) ? 2'd2 : ((mag > v20) ? 2'd1 : 2'd0);
            end
        end
    end

    // Datapath registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mix_reg <= '0;
            mixValid_reg <= 1'b0;
            mon_reg <= '0;
            peak_reg <= 8'h00;
            vu_reg <= 16'h0000;
        end else if (clkEn) begin
            mix_reg <= mix_next;
            mixValid_reg <= mixValid_next;
            mon_reg <= mon_next;
            peak_reg <= peak_next;
            vu_reg <= vu_next;
        end
    end

    // Stall input while a frame waits for the buffer
    assign inReady = !mixValid_reg;

    // Two-entry output buffer
    agmr_buf2 #(.WIDTH(NCH*SMP_W)) outBuf (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .inValid(mixValid_reg),
        .inReady(bufReady),
        .inData(mix_reg),
        .outValid(outValid),
        .outReady(outReady),
        .outData(outSamples)
    );

    // Outputs
    assign avsReadData = rdata_reg;
    assign avsWaitRequest = !ack_reg;
    assign monSamples = mon_reg;
    assign selGroupA = ctrl_reg[CTRL_GA+:3];
    assign selGroupB = ctrl_reg[CTRL_GB+:3];
    assign demuxMode = ctrl_reg[CTRL_DEMUX];
endmodule // agmr_mixer
`default_nettype wire

// ==== rtl/agmr_pkg.sv ====
package agmr_pkg;
    // Bus and data widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SMP_W = 24;
    localparam int NCH = 8;
    localparam int GAIN_W = 8;
    localparam int ACC_W = 40;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MON = 8'h08;
    localparam logic [7:0] OFF_TIE = 8'h0C;
    localparam logic [7:0] OFF_DEFAULT = 8'h10;
    localparam logic [7:0] OFF_INVERT = 8'h14;
    localparam logic [7:0] OFF_DATA = 8'h18;
    localparam logic [7:0] OFF_PEAK = 8'h1C;
    localparam logic [7:0] OFF_VU = 8'h20;
    localparam logic [7:0] OFF_GAIN0 = 8'h40;
    localparam logic [7:0] OFF_ROUTE0 = 8'h60;
    // Group selector codes
    localparam logic [2:0] GRP_OFF = 3'h0;
    localparam logic [2:0] GRP_MAX = 3'h4;
    // Status codes
    localparam logic [2:0] STS_NONE = 3'h0;
    localparam logic [2:0] STS_OFF = 3'h5;
    // Gain code: dB offset by 70, 0..82 spans -70..+12 dB
    localparam logic [7:0] GAIN_UNITY = 8'h0046;
    localparam logic [7:0] GAIN_MAXC = 8'h0052;
    // Monitor volume in percent
    localparam logic [6:0] VOL_FULL = 7'h64;
    localparam logic [6:0] VOL_DIV = 7'h64;
    // Headroom thresholds (magnitude of full scale minus 0,2,4,6,8,10 dB)
    localparam logic [22:0] PEAK_CLIP = 23'h7F_FFFF;
    localparam logic [22:0] PEAK_2DB = 23'h65_AC8C;
    localparam logic [22:0] PEAK_4DB = 23'h50_C335;
    localparam logic [22:0] PEAK_6DB = 23'h40_2C6A;
    localparam logic [22:0] PEAK_8DB = 23'h32_F52C;
    localparam logic [22:0] PEAK_10DB = 23'h28_7A26;
    // VU references: -18 and -20 dBFS, and a further 20 dB down
    localparam logic [22:0] VU18_0 = 23'h10_13B9;
    localparam logic [22:0] VU20_0 = 23'h0C_CCCC;
    localparam logic [22:0] VU18_M20 = 23'h01_9C86;
    localparam logic [22:0] VU20_M20 = 23'h01_47AE;
    // Control field positions
    localparam int CTRL_GA = 0;
    localparam int CTRL_GB = 4;
    localparam int CTRL_DEMUX = 8;
    localparam int CTRL_PEAK = 12;
    localparam int CTRL_REF = 16;
    // Two-entry buffer depth
    localparam int BUF_DEPTH = 2;
endpackage : agmr_pkg

// ==== tb/agmr_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far-side stream model: feeds input frames, collects mixed frames
module agmr_far_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Toward the mixer input
    output logic inValid,
    input wire logic inReady,
    output logic [agmr_pkg::NCH*agmr_pkg::SMP_W-1:0] inSamples,
    // From the mixer output
    input wire logic outValid,
    output logic outReady,
    input wire logic [agmr_pkg::NCH*agmr_pkg::SMP_W-1:0] outSamples,
    // Bench control
    input wire logic stall
);
    import agmr_pkg::*;
    logic [NCH*SMP_W-1:0] txq[$]; // Frames waiting to go out
    logic [NCH*SMP_W-1:0] rxq[$]; // Frames taken from the mixer
    // Stall refuses the mixer output
    assign outReady = !stall;
    // Frame held until taken; idle data keeps changing
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            inValid <= 1'b0;
            inSamples <= '0;
        end else begin
            if (outValid && outReady) begin
                rxq.push_back(outSamples);
            end
            if (!inValid || inReady) begin
                if (txq.size() > 0) begin
                    inValid <= 1'b1;
                    inSamples <= txq.pop_front();
                end else begin
                    inValid <= 1'b0;
                    inSamples <= ~inSamples;
                end
            end
        end
    end
endmodule // agmr_far_model
`default_nettype wire

// ==== tb/agmr_mixer_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the mixer
module agmr_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Register bus
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitRequest,
    // Stream
    input wire logic inValid,
    input wire logic inReady,
    input wire logic outValid,
    input wire logic outReady,
    input wire logic [agmr_pkg::NCH*agmr_pkg::SMP_W-1:0] outSamples,
    // Group selection
    input wire logic [2:0] selGroupA,
    input wire logic [2:0] selGroupB
);
    import agmr_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    // Answer one cycle after a request is taken
    a_ack_prompt: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("bus answer late");
    a_ack_single: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("bus answer longer than one cycle");
    a_ack_cause: assert property (!avsWaitRequest |-> $past(avsRead || avsWrite))
        else $error("bus answer without request");
    // Selectors stay within their legal codes
    a_sel_a_range: assert property (selGroupA inside {[3'h1:3'h4]})
        else $error("primary selector illegal");
    a_sel_b_range: assert property (selGroupB <= GRP_MAX)
        else $error("secondary selector illegal");
    // Stream handshake and buffering
    a_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outSamples))
        else $error("output frame dropped under stall");
    a_in_busy: assert property (inValid && inReady |=> !inReady)
        else $error("input accepted while mix stage full");
    a_out_soon: assert property (inValid && inReady && !outValid |-> ##[1:3] outValid)
        else $error("mixed frame late");
endmodule // agmr_checker
bind agmr_mixer agmr_checker u_chk (.core_clk, .arst_n, .avsRead, .avsWrite, .avsWaitRequest, .inValid,
    .inReady, .outValid, .outReady, .outSamples, .selGroupA, .selGroupB);
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import agmr_pkg::*;
    // Selector table row: control word, presence, status
    typedef struct packed {
        logic [31:0] ctrl;
        logic [3:0] pres;
        logic [31:0] sts;
    } agmr_row_t;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clkEn = 1'b1;
    logic [7:0] avsAddress = 8'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0000_0000;
    logic [31:0] avsReadData, rdv;
    logic avsWaitRequest, inValid, inReady, outValid, outReady, demuxMode;
    logic stall = 1'b0;
    logic [3:0] grpPresent = 4'h0;
    logic [191:0] inSamples, outSamples, fi, fe, fo;
    logic [47:0] monSamples;
    logic [2:0] selGroupA, selGroupB;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    agmr_row_t rows[4] = '{'{32'h0000_0001, 4'h1, 32'h0000_0051}, '{32'h0000_0032, 4'h2, 32'h0000_0002},
        '{32'h0000_0044, 4'h8, 32'h0000_0044}, '{32'h0000_0113, 4'h1, 32'h0000_0010}};
    always #5 core_clk = ~core_clk;
    agmr_mixer uut (.core_clk, .arst_n, .clkEn, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
        .avsReadData, .avsWaitRequest, .grpPresent, .inValid, .inReady, .inSamples, .outValid,
        .outReady, .outSamples, .monSamples, .selGroupA, .selGroupB, .demuxMode);
    agmr_far_model far (.core_clk, .arst_n, .inValid, .inReady, .inSamples, .outValid, .outReady,
        .outSamples, .stall);
    // ****************
    // Shared tasks
    // ****************
    task chk(input string name, input logic [191:0] seen, input logic [191:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Bus write held until waitrequest is seen low
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= 1'b1;
        do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
        avsWrite <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        avsAddress <= a;
        avsRead <= 1'b1;
        do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
        rdv = avsReadData;
        avsRead <= 1'b0;
    endtask
    // Send one frame and collect the mixed result
    task snd(input logic [191:0] f);
        far.txq.push_back(f);
        while (far.rxq.size() == 0) @(posedge core_clk);
        fo = far.rxq.pop_front();
        @(posedge core_clk);
    endtask
    task wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up;
        end
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        chk("selA rst", selGroupA, 3'h1);
        chk("selB rst", selGroupB, GRP_OFF);
        chk("demux rst", demuxMode, 1'b0);
        chk("outValid rst", outValid, 1'b0);
        rd(OFF_MON);
        chk("mon rst", rdv[14:0], 15'h6400);
        // Selector and status table
        foreach (rows[i]) begin
            grpPresent <= rows[i].pres;
            wr(OFF_CTRL, rows[i].ctrl);
            repeat (4) @(posedge core_clk);
            rd(OFF_STATUS);
            chk("status", rdv[6:0], rows[i].sts[6:0]);
            chk("selA", selGroupA, rows[i].ctrl[2:0]);
            chk("selB", selGroupB, rows[i].ctrl[6:4]);
            chk("demux", demuxMode, rows[i].ctrl[8]);
        end
        // Illegal selector codes leave the old choice
        wr(OFF_CTRL, 32'h0000_0050);
        chk("selA kept", selGroupA, 3'h3);
        chk("selB kept", selGroupB, 3'h1);
        rd(8'h3C);
        chk("unmapped", rdv, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0001);
        // Unity path, invert, routing, non-audio
        for (int i = 0; i < 8; i++) fi[i*24+:24] = 24'(32'h0000_1000 * (i + 1));
        snd(fi);
        chk("unity", fo, fi);
        chk("mon 1/2", monSamples, fi[47:0]);
        wr(OFF_INVERT, 32'h0000_0001);
        snd(fi);
        fe = fi;
        fe[23:0] = -fi[23:0];
        chk("invert", fo, fe);
        wr(OFF_INVERT, 32'h0000_0000);
        wr(OFF_ROUTE0 + 8'h04, 32'h0000_0023);
        snd(fi);
        fe = fi;
        fe[23:0] = fi[23:0] + fi[47:24];
        fe[143:120] = fi[143:120] + fi[47:24];
        chk("route", fo, fe);
        wr(OFF_DATA, 32'h0000_0002);
        wr(OFF_INVERT, 32'h0000_0002);
        snd(fi);
        chk("data ch", fo, fi);
        wr(OFF_DATA, 32'h0000_0000);
        wr(OFF_INVERT, 32'h0000_0000);
        wr(OFF_ROUTE0 + 8'h04, 32'h0000_0002);
        // Gain range and default
        wr(OFF_GAIN0 + 8'h08, 32'h0000_0040);
        wr(OFF_GAIN0 + 8'h08, 32'h0000_0053);
        rd(OFF_GAIN0 + 8'h08);
        chk("gain kept", rdv[7:0], 8'h40);
        wr(OFF_GAIN0 + 8'h08, 32'h0000_0052);
        snd(fi);
        chk("gain max", $signed(fo[71:48]) > $signed(24'h00_6000), 1'b1);
        wr(OFF_DEFAULT, 32'h0000_0004);
        rd(OFF_GAIN0 + 8'h08);
        chk("gain default", rdv[7:0], GAIN_UNITY);
        // Tie: gain of channel 2 follows its partner, channel 1
        wr(OFF_TIE, 32'h0000_0001);
        wr(OFF_GAIN0, 32'h0000_0030);
        snd(fi);
        chk("tie", $signed(fo[47:24]) < $signed(24'h00_1000), 1'b1);
        wr(OFF_DEFAULT, 32'h0000_0003);
        wr(OFF_TIE, 32'h0000_0000);
        // Monitor pair and volume
        wr(OFF_MON, 32'h0000_6403);
        snd(fi);
        chk("mon 7/8", monSamples, fi[191:144]);
        wr(OFF_MON, 32'h0000_0003);
        snd(fi);
        chk("mon mute", monSamples, 48'h0000_0000_0000);
        wr(OFF_MON, 32'h0000_6503);
        rd(OFF_MON);
        chk("vol kept", rdv[14:0], 15'h0003);
        wr(OFF_MON, 32'h0000_6400);
        // Peak and VU at 6 dB headroom, then after unrouting, then clipping
        fe = '0;
        fe[23:0] = 24'h50_0000;
        fe[47:24] = 24'h02_0000;
        fe[71:48] = 24'h00_0100;
        fe[95:72] = 24'hB0_0000;
        wr(OFF_CTRL, 32'h0000_3001);
        snd(fe);
        rd(OFF_PEAK);
        chk("peak", rdv[7:0], 8'h09);
        rd(OFF_VU);
        chk("vu", rdv[15:0], 16'h0086);
        wr(OFF_ROUTE0, 32'h0000_0000);
        snd(fe);
        rd(OFF_PEAK);
        chk("peak unrouted", rdv[7:0], 8'h08);
        wr(OFF_CTRL, 32'h0000_0001);
        snd(fe);
        rd(OFF_PEAK);
        chk("peak clip", rdv[7:0], 8'h00);
        wr(OFF_ROUTE0, 32'h0000_0001);
        // Stall fills the buffer; no frame may be lost
        stall <= 1'b1;
        for (int k = 0; k < 4; k++) far.txq.push_back({fi[191:8], 8'(k)});
        repeat (20) @(posedge core_clk);
        chk("in refused", inReady, 1'b0);
        chk("out held", outValid, 1'b1);
        stall <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            while (far.rxq.size() == 0) @(posedge core_clk);
            chk("order", far.rxq.pop_front(), {fi[191:8], 8'(k)});
        end
        wrap_up;
    end
endmodule // tb
`default_nettype wire
